// file: core/dsbc_framer.sv
/*
 dsbc_framer: register file, sync/blanking/command packet framer, receive
 capture buffer and transmit command buffer of the display link host.
 Assumes one clock, synchronous reset, a byte-addressed Avalon-MM master and
 a downstream byte consumer with valid/ready.
*/
`timescale 1ns/1ps
// Operation
// R01: The hsync end header is sent as its four programmed bytes, data type in 5:0 and ECC in 31:24.
// R02: The vsync start header is sent as its four programmed bytes as the vsync start event.
// R03: The vsync end header is sent as its four programmed bytes as the vsync end event.
// R04: Bits 23:8 of each blanking header give the number of payload bytes sent in that packet.
// R05: A blanking payload is the fill byte repeated that many times, then the 16-bit footer.
// R06: Bit 26 of the command word is set on receive buffer overrun and cleared by writing one.
// R07: Bit 25 is set when a reception completes and cleared by writing one.
// R08: Bit 24 reads one while a reception is in progress.
// R09: Bits 20:16 hold the last reception length minus one.
// R10: Bit 9 is set when a transmission completes and cleared by writing one.
// R11: Bit 8 reads one while a transmission is pending.
// R12: Software writes bits 7:0 with the byte count minus one and that many plus one bytes go out.
// R13: The receive buffer is eight words from 0x240, lowest byte in bits 7:0, filled by the link.
// R14: The receive buffer is read only after the flag is set and is never flushed by hardware.
// R15: The transmit buffer is 256 words from 0x300, byte zero lowest, sent as a command packet.
module dsbc_framer
   import dsbc_pkg::*;
(
   // clock and reset
   input wire logic clk,
   input wire logic sys_rst,
   // avalon-mm slave
   input wire logic [ADDR_W-1:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic [3:0] avs_byteenable,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   // packet request from the instruction engine
   input wire logic reqValid,
   input wire dsbc_kind_e reqKind,
   output logic reqReady,
   output logic pktDone,
   // byte stream toward the lane serialiser
   output logic [7:0] outData,
   output logic outLast,
   output logic outValid,
   input wire logic outReady,
   // low-power receive bytes from the panel
   input wire logic rxValid,
   input wire logic [7:0] rxData,
   input wire logic rxLast
);
   // whole control state of the block
   typedef struct packed {
      dsbc_state_e fsm;
      dsbc_kind_e kind;
      logic [15:0] idx;
      logic [2:0][31:0] syncHdr;
      logic [NUM_BLANK-1:0][31:0] blankHdr;
      logic [NUM_BLANK-1:0][31:0] blankFill;
      dsbc_byte_s [1:0] fifo;
      logic [1:0] fifoCnt;
      logic [5:0] rxCnt;
      logic rxPend;
      logic rxFlag;
      logic rxOvf;
      logic [4:0] rxSize;
      logic txFlag;
      logic txPend;
      logic [7:0] txSize;
      logic rdValid;
      logic [31:0] rdData;
      logic done;
   } dsbc_state_s;

   dsbc_state_s st_ff;
   dsbc_state_s nxt_st;
   logic [7:0] rxMem [RX_BYTES];
   logic [3:0][7:0] txMem [TX_WORDS];

   logic busWr;
   logic busRd;
   logic rxHit;
   logic txHit;
   logic rxTake;
   logic push;
   logic pop;
   dsbc_byte_s pushByte;
   logic [31:0] hdrWord;
   logic [31:0] fillWord;
   logic [15:0] wc;
   logic [31:0] beMask;
   logic [31:0] ctlWord;
   logic [10:0] txOfs;

   // bus strobes and buffer windows
   assign busWr = avs_write;
   assign busRd = avs_read && !st_ff.rdValid;
   assign rxHit = (avs_address >= OFS_RX_BASE) && (avs_address < OFS_TX_BASE)
                  && (avs_address[7:5] == OFS_RX_BASE[7:5]);
   // transmit words count from their own base, so word n sits at txMem[n]
   assign txOfs = avs_address - OFS_TX_BASE;
   assign txHit = (avs_address >= OFS_TX_BASE) && (txOfs < 11'(4 * TX_WORDS));
   assign beMask = {{8{avs_byteenable[3]}}, {8{avs_byteenable[2]}},
                    {8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};
   assign rxTake = rxValid && (st_ff.rxCnt < 6'(RX_BYTES));

   // reads stall one cycle so read data come from a flop
   assign avs_waitrequest = avs_read && !st_ff.rdValid;
   assign avs_readdata = st_ff.rdData;

   // outward stream comes straight from the buffer head
   assign outData = st_ff.fifo[0].data;
   assign outLast = st_ff.fifo[0].last;
   assign outValid = (st_ff.fifoCnt != 2'b00);
   assign pop = outValid && outReady;
   assign reqReady = (st_ff.fsm == ST_IDLE);
   assign pktDone = st_ff.done;

   // command control word as software sees it
   assign ctlWord = {5'h00, st_ff.rxOvf, st_ff.rxFlag, st_ff.rxPend, 3'h0,
                     st_ff.rxSize, 6'h00, st_ff.txFlag, st_ff.txPend, st_ff.txSize};

   // header and fill words of the packet in flight
   always_comb begin
      hdrWord = RST_WORD;
      fillWord = RST_WORD;
      if (st_ff.kind <= KIND_VSYNC_END) begin
         hdrWord = st_ff.syncHdr[2'(st_ff.kind)];
      end else if (st_ff.kind <= KIND_FRAME_BLANK) begin
         hdrWord = st_ff.blankHdr[3'(st_ff.kind - KIND_HSYNC_ACTIVE)];
         fillWord = st_ff.blankFill[3'(st_ff.kind - KIND_HSYNC_ACTIVE)];
      end
   end
   assign wc = hdrWord[WC_MSB:WC_LSB]; // R04

   // byte the framer offers this cycle
   always_comb begin
      pushByte = '{data: 8'h00, last: 1'b0};
      push = 1'b0;
      case (st_ff.fsm)
         ST_HDR: begin
            push = (st_ff.fifoCnt != 2'b10);
            pushByte.data = hdrWord[8*st_ff.idx[1:0] +: 8]; // R01 R02 R03
            pushByte.last = (st_ff.idx[1:0] == 2'b11) && (st_ff.kind <= KIND_VSYNC_END);
         end
         ST_FILL: begin
            push = (st_ff.fifoCnt != 2'b10);
            pushByte.data = fillWord[FILL_LSB +: 8]; // R05
         end
         ST_FOOT: begin
            push = (st_ff.fifoCnt != 2'b10);
            pushByte.data = fillWord[FOOT_LSB + 8*st_ff.idx[0] +: 8]; // R05
            pushByte.last = st_ff.idx[0];
         end
         ST_CMD: begin
            push = (st_ff.fifoCnt != 2'b10);
            pushByte.data = txMem[st_ff.idx[9:2]][st_ff.idx[1:0]]; // R15
            pushByte.last = (st_ff.idx == {8'h00, st_ff.txSize}); // R12
         end
         default: begin
            push = 1'b0;
         end
      endcase
   end

   // next state: bus writes, framer sequence, buffer, receive status
   always_comb begin
      nxt_st = st_ff;
      nxt_st.done = 1'b0;
      nxt_st.rdValid = busRd;
      // register read mux
      if (busRd) begin
         nxt_st.rdData = RST_WORD;
         case (avs_address)
            OFS_HSYNC_END: nxt_st.rdData = st_ff.syncHdr[0];
            OFS_VSYNC_START: nxt_st.rdData = st_ff.syncHdr[1];
            OFS_VSYNC_END: nxt_st.rdData = st_ff.syncHdr[2];
            OFS_CMD_CTL: nxt_st.rdData = ctlWord;
            default: begin
               for (int b = 0; b < NUM_BLANK; b++) begin
                  if (avs_address == OFS_BLANK_HDR[b]) begin
                     nxt_st.rdData = st_ff.blankHdr[b];
                  end
                  if (avs_address == OFS_BLANK_FILL[b]) begin
                     nxt_st.rdData = st_ff.blankFill[b];
                  end
               end
               if (rxHit) begin
                  nxt_st.rdData = {rxMem[{avs_address[4:2], 2'b11}],
                                   rxMem[{avs_address[4:2], 2'b10}],
                                   rxMem[{avs_address[4:2], 2'b01}],
                                   rxMem[{avs_address[4:2], 2'b00}]}; // R13 R14
               end
               if (txHit) begin
                  nxt_st.rdData = txMem[txOfs[9:2]];
               end
            end
         endcase
      end
      // register writes honour byte enables; flags are write-one-to-clear
      if (busWr) begin
         case (avs_address)
            OFS_HSYNC_END: nxt_st.syncHdr[0] = (st_ff.syncHdr[0] & ~beMask)
                                               | (avs_writedata & beMask);
            OFS_VSYNC_START: nxt_st.syncHdr[1] = (st_ff.syncHdr[1] & ~beMask)
                                                 | (avs_writedata & beMask);
            OFS_VSYNC_END: nxt_st.syncHdr[2] = (st_ff.syncHdr[2] & ~beMask)
                                               | (avs_writedata & beMask);
            OFS_CMD_CTL: begin
               if (avs_byteenable[3] && avs_writedata[CTL_RX_OVF]) begin
                  nxt_st.rxOvf = 1'b0; // R06
               end
               if (avs_byteenable[3] && avs_writedata[CTL_RX_FLAG]) begin
                  nxt_st.rxFlag = 1'b0; // R07
               end
               if (avs_byteenable[1] && avs_writedata[CTL_TX_FLAG]) begin
                  nxt_st.txFlag = 1'b0; // R10
               end
               if (avs_byteenable[0]) begin
                  nxt_st.txSize = avs_writedata[CTL_TX_SIZE_LSB +: 8]; // R12
               end
            end
            default: begin
               for (int b = 0; b < NUM_BLANK; b++) begin
                  if (avs_address == OFS_BLANK_HDR[b]) begin
                     nxt_st.blankHdr[b] = (st_ff.blankHdr[b] & ~beMask)
                                          | (avs_writedata & beMask);
                  end
                  if (avs_address == OFS_BLANK_FILL[b]) begin
                     nxt_st.blankFill[b] = ((st_ff.blankFill[b] & ~beMask)
                                            | (avs_writedata & beMask)) & FILL_MASK;
                  end
               end
            end
         endcase
      end
      // framer sequence
      case (st_ff.fsm)
         ST_IDLE: begin
            if (reqValid) begin
               nxt_st.kind = reqKind;
               nxt_st.idx = 16'h0000;
               if (reqKind == KIND_COMMAND) begin
                  nxt_st.fsm = ST_CMD;
                  nxt_st.txPend = 1'b1; // R11
               end else if (reqKind <= KIND_FRAME_BLANK) begin
                  nxt_st.fsm = ST_HDR;
               end
            end
         end
         ST_HDR: begin
            if (push) begin
               nxt_st.idx = st_ff.idx + 16'h0001;
               if (st_ff.idx[1:0] == 2'b11) begin
                  nxt_st.idx = 16'h0000;
                  if (st_ff.kind <= KIND_VSYNC_END) begin
                     nxt_st.fsm = ST_IDLE;
                     nxt_st.done = 1'b1;
                  end else if (wc == 16'h0000) begin
                     nxt_st.fsm = ST_FOOT;
                  end else begin
                     nxt_st.fsm = ST_FILL; // R04
                  end
               end
            end
         end
         ST_FILL: begin
            if (push) begin
               nxt_st.idx = st_ff.idx + 16'h0001;
               if (st_ff.idx == wc - 16'h0001) begin
                  nxt_st.idx = 16'h0000;
                  nxt_st.fsm = ST_FOOT; // R05
               end
            end
         end
         ST_FOOT: begin
            if (push) begin
               nxt_st.idx = st_ff.idx + 16'h0001;
               if (st_ff.idx[0]) begin
                  nxt_st.fsm = ST_IDLE;
                  nxt_st.done = 1'b1;
               end
            end
         end
         ST_CMD: begin
            if (push) begin
               nxt_st.idx = st_ff.idx + 16'h0001;
               if (pushByte.last) begin
                  nxt_st.fsm = ST_IDLE;
                  nxt_st.done = 1'b1;
                  nxt_st.txPend = 1'b0; // R11
                  nxt_st.txFlag = 1'b1; // R10
               end
            end
         end
         default: begin
            nxt_st.fsm = ST_IDLE;
         end
      endcase
      // two-entry buffer: a stalled consumer holds the framer, no byte lost
      case ({push, pop})
         2'b10: begin
            nxt_st.fifo[st_ff.fifoCnt[0]] = pushByte;
            nxt_st.fifoCnt = st_ff.fifoCnt + 2'b01;
         end
         2'b01: begin
            nxt_st.fifo[0] = st_ff.fifo[1];
            nxt_st.fifoCnt = st_ff.fifoCnt - 2'b01;
         end
         2'b11: begin
            if (st_ff.fifoCnt == 2'b01) begin
               nxt_st.fifo[0] = pushByte;
            end else begin
               nxt_st.fifo[0] = st_ff.fifo[1];
               nxt_st.fifo[1] = pushByte;
            end
         end
         default: begin
            nxt_st.fifoCnt = st_ff.fifoCnt;
         end
      endcase
      // receive status; a set in the clearing cycle wins
      if (rxValid) begin
         if (rxTake) begin
            nxt_st.rxCnt = st_ff.rxCnt + 6'h01;
         end else begin
            nxt_st.rxOvf = 1'b1; // R06
         end
         nxt_st.rxPend = !rxLast; // R08
         if (rxLast) begin
            nxt_st.rxCnt = 6'h00;
            nxt_st.rxFlag = 1'b1; // R07
            nxt_st.rxSize = rxTake ? st_ff.rxCnt[4:0] : 5'h1f; // R09
         end
      end
   end

   // state register
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         st_ff <= '0;
      end else begin
         st_ff <= nxt_st;
      end
   end

   // buffers: link bytes take the receive buffer ahead of software writes
   always_ff @(posedge clk) begin
      if (rxTake) begin
         rxMem[st_ff.rxCnt[4:0]] <= rxData; // R13
      end
      if (busWr && rxHit) begin
         for (int l = 0; l < 4; l++) begin
            if (avs_byteenable[l] && !(rxTake && st_ff.rxCnt[4:0] == {avs_address[4:2], 2'(l)}))
               begin
               rxMem[{avs_address[4:2], 2'(l)}] <= avs_writedata[8*l +: 8];
            end
         end
      end
      if (busWr && txHit) begin
         for (int l = 0; l < 4; l++) begin
            if (avs_byteenable[l]) begin
               txMem[txOfs[9:2]][l] <= avs_writedata[8*l +: 8]; // R15
            end
         end
      end
   end

   // checks
   default clocking cb @(posedge clk); endclocking
   default disable iff (sys_rst);

   property p_sync_last; // R01 R02 R03
      push && st_ff.fsm == ST_HDR && st_ff.kind <= KIND_VSYNC_END && st_ff.idx[1:0] == 2'b11
         |-> pushByte.last ##1 (st_ff.fsm == ST_IDLE && pktDone);
   endproperty
   a_sync_last: assert property (p_sync_last) else $error("sync packet not four bytes");
   property p_fill_len; // R04
      push && st_ff.fsm == ST_FILL && st_ff.idx == wc - 16'h0001 |=> st_ff.fsm == ST_FOOT;
   endproperty
   a_fill_len: assert property (p_fill_len) else $error("payload length wrong");
   property p_footer; // R05
      push && st_ff.fsm == ST_FOOT && st_ff.idx[0]
         |-> pushByte.last && pushByte.data == fillWord[FOOT_LSB + 8 +: 8];
   endproperty
   a_footer: assert property (p_footer) else $error("footer byte wrong");
   property p_ovf; // R06
      rxValid && st_ff.rxCnt == 6'(RX_BYTES) |=> st_ff.rxOvf;
   endproperty
   a_ovf: assert property (p_ovf) else $error("overrun not flagged");
   property p_rx_flag; // R07
      rxValid && rxLast |=> st_ff.rxFlag && !st_ff.rxPend;
   endproperty
   a_rx_flag: assert property (p_rx_flag) else $error("reception flag missing");
   property p_rx_pend; // R08
      rxValid && !rxLast |=> st_ff.rxPend;
   endproperty
   a_rx_pend: assert property (p_rx_pend) else $error("reception not pending");
   property p_rx_size; // R09
      rxValid && rxLast && rxTake |=> st_ff.rxSize == $past(st_ff.rxCnt[4:0]);
   endproperty
   a_rx_size: assert property (p_rx_size) else $error("reception size wrong");
   property p_tx_flag; // R10
      push && st_ff.fsm == ST_CMD && pushByte.last |=> st_ff.txFlag && !st_ff.txPend;
   endproperty
   a_tx_flag: assert property (p_tx_flag) else $error("transmit flag missing");
   property p_tx_pend; // R11
      reqReady && reqValid && reqKind == KIND_COMMAND |=> st_ff.txPend && st_ff.fsm == ST_CMD;
   endproperty
   a_tx_pend: assert property (p_tx_pend) else $error("transmit not pending");
   property p_rx_store; // R13
      rxTake |=> rxMem[$past(st_ff.rxCnt[4:0])] == $past(rxData);
   endproperty
   a_rx_store: assert property (p_rx_store) else $error("receive byte not stored");

   c_sync: cover property (st_ff.fsm == ST_HDR && st_ff.kind == KIND_VSYNC_START ##[1:20] pktDone);
   c_blank: cover property (st_ff.fsm == ST_FILL ##[1:40] st_ff.fsm == ST_FOOT);
   c_ovf: cover property (rxValid && !rxTake);
   c_stall: cover property (st_ff.fifoCnt == 2'b10 && !outReady);
endmodule // dsbc_framer

// file: inc/dsbc_pkg.sv
/*
 dsbc_pkg: offsets, field positions, reset values, packet kinds and carrier
 types of the sync, blanking and command packet section.
 Assumes a byte-addressed Avalon-MM slave with one 32-bit word per register.
*/
package dsbc_pkg;
   // register bus geometry
   localparam int ADDR_W = 11;
   localparam logic [31:0] RST_WORD = 32'h0000_0000;
   // register byte offsets
   localparam logic [10:0] OFS_HSYNC_END = 11'h0b4;
   localparam logic [10:0] OFS_VSYNC_START = 11'h0b8;
   localparam logic [10:0] OFS_VSYNC_END = 11'h0bc;
   localparam logic [10:0] OFS_CMD_CTL = 11'h200;
   localparam logic [10:0] OFS_RX_BASE = 11'h240;
   localparam logic [10:0] OFS_TX_BASE = 11'h300;
   localparam int NUM_BLANK = 5;
   // header and fill/footer offsets, one pair per blanking packet type
   localparam logic [10:0] OFS_BLANK_HDR [NUM_BLANK] =
      '{11'h0c0, 11'h0c8, 11'h0d0, 11'h0e0, 11'h0e8};
   localparam logic [10:0] OFS_BLANK_FILL [NUM_BLANK] =
      '{11'h0c4, 11'h0cc, 11'h0d4, 11'h0e4, 11'h0ec};
   // buffer sizes
   localparam int RX_WORDS = 8;
   localparam int RX_BYTES = 32;
   localparam int TX_WORDS = 256;
   // header word fields
   localparam int WC_LSB = 8;
   localparam int WC_MSB = 23;
   // fill word fields
   localparam int FILL_LSB = 0;
   localparam int FOOT_LSB = 16;
   localparam logic [31:0] FILL_MASK = 32'hffff_00ff;
   // command control word fields
   localparam int CTL_RX_OVF = 26;
   localparam int CTL_RX_FLAG = 25;
   localparam int CTL_RX_PEND = 24;
   localparam int CTL_RX_SIZE_LSB = 16;
   localparam int CTL_TX_FLAG = 9;
   localparam int CTL_TX_PEND = 8;
   localparam int CTL_TX_SIZE_LSB = 0;
   // packet kinds requested by the instruction engine
   typedef enum logic [3:0] {
      KIND_HSYNC_END = 4'h0,
      KIND_VSYNC_START = 4'h1,
      KIND_VSYNC_END = 4'h2,
      KIND_HSYNC_ACTIVE = 4'h3,
      KIND_BACK_PORCH = 4'h4,
      KIND_FRONT_PORCH = 4'h5,
      KIND_LINE_BLANK = 4'h6,
      KIND_FRAME_BLANK = 4'h7,
      KIND_COMMAND = 4'h8
   } dsbc_kind_e;
   // framer phases
   typedef enum logic [2:0] {
      ST_IDLE = 3'b000,
      ST_HDR = 3'b001,
      ST_FILL = 3'b010,
      ST_FOOT = 3'b011,
      ST_CMD = 3'b100
   } dsbc_state_e;
   // one link byte with end-of-packet mark
   typedef struct packed {
      logic [7:0] data;
      logic last;
   } dsbc_byte_s;
endpackage

// file: sim/dsbc_framer_test.sv
/*
 dsbc_framer_test: self-checking bench for the packet framer with random
 registers, packets and receive bursts. Assumes the panel model and package.
*/
`timescale 1ns/1ps
module dsbc_framer_test
   import dsbc_pkg::*;
;
   localparam logic [31:0] SYNC [3] = '{32'h0100_0031, 32'h0700_0001, 32'h1400_0011};
   localparam int SZ [3] = '{0, 255, 0};
   localparam int RXN [4] = '{32, 33, 1, 0};
   logic clk, sys_rst, avs_read, avs_write, avs_waitrequest, reqValid, reqReady;
   logic [ADDR_W-1:0] avs_address;
   logic [31:0] avs_writedata, avs_readdata, q, v, f, e;
   logic [3:0] avs_byteenable;
   dsbc_kind_e reqKind;
   logic [7:0] outData, rxData, b;
   logic outLast, outValid, outReady, rxValid, rxLast, holdOff;
   logic [31:0] txw [TX_WORDS];
   logic [7:0] rxm [RX_BYTES];
   dsbc_byte_s expQ[$];
   int failCount, checked, wc, sz, n;
   // design and far-side model
   dsbc_framer u_dut (.clk(clk), .sys_rst(sys_rst), .avs_address(avs_address),
      .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
      .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
      .avs_waitrequest(avs_waitrequest), .reqValid(reqValid), .reqKind(reqKind),
      .reqReady(reqReady), .pktDone(), .outData(outData), .outLast(outLast),
      .outValid(outValid), .outReady(outReady), .rxValid(rxValid), .rxData(rxData),
      .rxLast(rxLast));
   dsbc_panel u_panel (.clk(clk), .sys_rst(sys_rst), .outData(outData), .outLast(outLast),
      .outValid(outValid), .outReady(outReady), .holdOff(holdOff), .rxValid(rxValid),
      .rxData(rxData), .rxLast(rxLast));
   // free-running clock
   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end
   // comparisons and closing report
   task automatic chk_word(input logic [31:0] g, input logic [31:0] x);
      checked++;
      if (g !== x) begin
         failCount++;
         $display("unexpected word at %0t: got %h want %h", $time, g, x);
      end
   endtask
   task automatic chk_byte(input dsbc_byte_s g, input dsbc_byte_s x);
      checked++;
      if (g !== x) begin
         failCount++;
         $display("unexpected byte at %0t: got %h want %h", $time, g, x);
      end
   endtask
   task automatic conclude();
      $display("checks %0d mismatches %0d", checked, failCount);
      if (failCount == 0 && checked > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask
   task automatic hang();
      failCount++;
      $display("unexpected timeout at %0t", $time);
      conclude();
   endtask
   // one avalon transfer, held until waitrequest is seen low at an edge
   task automatic bus(input logic wr, input logic [10:0] a, input logic [31:0] d,
      input logic [3:0] be, output logic [31:0] r);
      int t;
      logic ws;
      t = 0;
      avs_address <= a;
      avs_writedata <= d;
      avs_byteenable <= be;
      avs_write <= wr;
      avs_read <= !wr;
      do begin
         @(posedge clk);
         ws = avs_waitrequest;
         r = avs_readdata;
         t++;
         if (t > 50) hang();
      end while (ws);
      avs_write <= 1'b0;
      avs_read <= 1'b0;
      @(posedge clk);
   endtask
   task automatic wr(input logic [10:0] a, input logic [31:0] d);
      bus(1'b1, a, d, 4'hf, q);
   endtask
   task automatic rd(input logic [10:0] a);
      bus(1'b0, a, 32'h0000_0000, 4'hf, q);
   endtask
   // expected bytes of a word, lowest byte first
   function automatic void put(input logic [31:0] x, input int nb, input logic el);
      for (int i = 0; i < nb; i++) begin
         expQ.push_back('{data: x[8*i +: 8], last: el && (i == nb - 1)});
      end
   endfunction
   // raise a packet request and hold it until taken
   task automatic req(input dsbc_kind_e k);
      int t;
      logic rdy;
      t = 0;
      reqKind <= k;
      reqValid <= 1'b1;
      do begin
         @(posedge clk);
         rdy = reqReady;
         t++;
         if (t > 50) hang();
      end while (!rdy);
      reqValid <= 1'b0;
   endtask
   // wait for the whole packet at the panel and compare it byte by byte
   task automatic drain();
      int t;
      t = 0;
      while (u_panel.gotQ.size() < expQ.size()) begin
         @(posedge clk);
         t++;
         if (t > 3000) hang();
      end
      repeat (4) @(posedge clk);
      chk_word(32'(u_panel.gotQ.size()), 32'(expQ.size()));
      foreach (expQ[i]) begin
         if (i < u_panel.gotQ.size()) chk_byte(u_panel.gotQ[i], expQ[i]);
      end
      expQ.delete();
      u_panel.gotQ.delete();
   endtask
   // main sequence
   initial begin
      void'($urandom(32'hc13c3d89));
      failCount = 0;
      checked = 0;
      sys_rst = 1'b1;
      avs_address = '0;
      avs_read = 1'b0;
      avs_write = 1'b0;
      avs_writedata = 32'h0000_0000;
      avs_byteenable = 4'h0;
      reqValid = 1'b0;
      reqKind = KIND_HSYNC_END;
      holdOff = 1'b0;
      repeat (3) @(posedge clk);
      sys_rst <= 1'b0;
      @(posedge clk);
      // reset values, then an unmapped place
      for (int i = 0; i < NUM_BLANK; i++) begin
         rd(OFS_BLANK_HDR[i]);
         chk_word(q, RST_WORD);
         rd(OFS_BLANK_FILL[i]);
         chk_word(q, RST_WORD);
      end
      rd(OFS_CMD_CTL);
      chk_word(q, RST_WORD);
      wr(11'h0a0, $urandom());
      rd(11'h0a0);
      chk_word(q, 32'h0000_0000);
      // sync headers with a random channel in 7:6
      for (int i = 0; i < 3; i++) begin
         rd(OFS_HSYNC_END + 11'(4 * i));
         chk_word(q, RST_WORD);
         v = SYNC[i] | ($urandom_range(3) << 6);
         wr(OFS_HSYNC_END + 11'(4 * i), v);
         put(v, 4, 1'b1);
         req(dsbc_kind_e'(i));
         drain();
      end
      bus(1'b1, OFS_VSYNC_END, 32'hffff_ffff, 4'h5, q);
      rd(OFS_VSYNC_END);
      chk_word(q, (v & 32'hff00_ff00) | 32'h00ff_00ff);
      // blanking packets: empty payload first, then random lengths
      for (int p = 0; p < 2; p++) begin
         for (int i = 0; i < NUM_BLANK; i++) begin
            wc = (p == 0) ? 0 : $urandom_range(9, 1);
            v = $urandom();
            v[23:8] = 16'(wc);
            f = $urandom();
            wr(OFS_BLANK_HDR[i], v);
            wr(OFS_BLANK_FILL[i], f);
            rd(OFS_BLANK_FILL[i]);
            chk_word(q, f & FILL_MASK);
            put(v, 4, 1'b0);
            repeat (wc) put(f, 1, 1'b0);
            put(f >> 16, 2, 1'b1);
            req(dsbc_kind_e'(3 + i));
            drain();
         end
      end
      // command buffer: shortest, longest with a stalled panel, random length
      for (int i = 0; i < TX_WORDS; i++) begin
         txw[i] = $urandom();
         wr(OFS_TX_BASE + 11'(4 * i), txw[i]);
      end
      rd(OFS_TX_BASE + 11'(4 * (TX_WORDS - 1)));
      chk_word(q, txw[TX_WORDS-1]);
      foreach (SZ[k]) begin
         sz = (k == 2) ? $urandom_range(40, 1) : SZ[k];
         wr(OFS_CMD_CTL, 32'(sz));
         for (int j = 0; j <= sz; j++) put(txw[j / 4] >> (8 * (j % 4)), 1, j == sz);
         holdOff <= (sz == 255);
         req(KIND_COMMAND);
         if (sz == 255) begin
            rd(OFS_CMD_CTL);
            chk_word(q, 32'h0000_01ff);
            holdOff <= 1'b0;
         end
         drain();
         rd(OFS_CMD_CTL);
         chk_word(q, 32'h0000_0200 | sz);
         wr(OFS_CMD_CTL, 32'(sz));
         rd(OFS_CMD_CTL);
         chk_word(q, 32'h0000_0200 | sz);
         wr(OFS_CMD_CTL, 32'h0000_0200 | sz);
         rd(OFS_CMD_CTL);
         chk_word(q, 32'(sz));
      end
      // receive bursts: full buffer, overrun, single byte, random length
      foreach (RXN[k]) begin
         n = (k == 3) ? $urandom_range(31, 2) : RXN[k];
         for (int j = 0; j < n; j++) begin
            b = 8'($urandom());
            if (j < RX_BYTES) rxm[j] = b;
            u_panel.send_rx(b, j == n - 1);
            if (j == 0 && n > 1) begin
               rd(OFS_CMD_CTL);
               chk_word(q & 32'h0100_0000, 32'h0100_0000);
            end
         end
         e = {5'h00, 1'(n > 32), 1'b1, 4'h0, 5'(n > 32 ? 31 : n - 1), 16'h0000};
         rd(OFS_CMD_CTL);
         chk_word(q & 32'hffff_0000, e);
         for (int i = 0; i < RX_WORDS; i++) begin
            rd(OFS_RX_BASE + 11'(4 * i));
            chk_word(q, {rxm[4*i+3], rxm[4*i+2], rxm[4*i+1], rxm[4*i]});
         end
         wr(OFS_CMD_CTL, 32'h0000_0000);
         rd(OFS_CMD_CTL);
         chk_word(q & 32'hffff_0000, e);
         wr(OFS_CMD_CTL, 32'h0600_0000);
         rd(OFS_CMD_CTL);
         chk_word(q & 32'hffff_0000, e & 32'h001f_0000);
      end
      conclude();
   end
endmodule // dsbc_framer_test

// file: sim/dsbc_panel.sv
/*
 dsbc_panel: far-side panel model; takes link bytes with random stalls and
 sends low-power bytes back. Assumes the framer's clock and reset.
*/
`timescale 1ns/1ps
module dsbc_panel
   import dsbc_pkg::*;
(
   // clock and reset
   input wire logic clk,
   input wire logic sys_rst,
   // byte stream from the host
   input wire logic [7:0] outData,
   input wire logic outLast,
   input wire logic outValid,
   output logic outReady,
   input wire logic holdOff,
   // low-power bytes toward the host
   output logic rxValid,
   output logic [7:0] rxData,
   output logic rxLast
);
   dsbc_byte_s gotQ[$];
   // idle levels at time zero
   initial begin
      outReady = 1'b0;
      rxValid = 1'b0;
      rxData = 8'h00;
      rxLast = 1'b0;
   end
   // take a byte on each handshake, stall at random or on demand
   always @(posedge clk) begin
      if (!sys_rst && outValid && outReady) begin
         gotQ.push_back('{data: outData, last: outLast});
      end
      outReady <= !holdOff && ($urandom_range(3) != 0);
   end
   // one low-power byte as a one-cycle pulse; the released line shows the inverse
   task automatic send_rx(input logic [7:0] b, input logic last);
      rxValid <= 1'b1;
      rxData <= b;
      rxLast <= last;
      @(posedge clk);
      rxValid <= 1'b0;
      rxLast <= 1'b0;
      rxData <= ~b;
      @(posedge clk);
   endtask
endmodule // dsbc_panel
